//--- tps_prescaler.sv
/*
 * shared timer prescaler with tick source selection, synchronisation
 * hold, external count pin edge ticks and an AXI4-Lite register slave.
 * assumes one clock aclk, synchronous active-low aresetn, and the
 * count pins already in the aclk domain only as far as sampling goes.
 */
// Behaviour
// - both timers share one divider, each with its own source select
// - select 1 ticks the timer every clock cycle
// - taps offer clock divided by 8, 64, 256 and 1024
// - divider runs freely whatever the selects say
// - first prescaled tick comes 1 to N cycles after enabling
// - the shared divider reset restarts the period for both timers
// - count pin sampled each cycle, synchronised, then edge detected
// - select 7 ticks on rising pin edges, 6 on falling ones
// - sampling stages clock on rising edge, front stage during high phase
// - pin edge reaches the counter 1.5 to 2.5 cycles later
// - pin ticks bypass the divider
// - hold bit keeps written divider resets asserted, timers halted by the shared one
// - clearing the hold bit clears both divider resets
// - shared reset bit resets the divider, self-clears unless held
// - no source selected means no ticks, count held
// - select 0 stops, 2 to 5 pick the taps in order
`timescale 1ns/1ps

module tps_prescaler (
   input  wire logic                                aclk,
   input  wire logic                                aresetn,
   input  wire logic [tps_pkg::ADDR_W-1:0]          awaddr,
   input  wire logic [2:0]                          awprot,
   input  wire logic                                awvalid,
   output      logic                                awready,
   input  wire logic [tps_pkg::DATA_W-1:0]          wdata,
   input  wire logic [tps_pkg::DATA_W/8-1:0]        wstrb,
   input  wire logic                                wvalid,
   output      logic                                wready,
   output      logic [1:0]                          bresp,
   output      logic                                bvalid,
   input  wire logic                                bready,
   input  wire logic [tps_pkg::ADDR_W-1:0]          araddr,
   input  wire logic [2:0]                          arprot,
   input  wire logic                                arvalid,
   output      logic                                arready,
   output      logic [tps_pkg::DATA_W-1:0]          rdata,
   output      logic [1:0]                          rresp,
   output      logic                                rvalid,
   input  wire logic                                rready,
   input  wire logic [tps_pkg::NUM_TIMERS-1:0]      ext_count_pin,
   output      logic [tps_pkg::NUM_TIMERS-1:0]      timer_tick,
   output      logic                                second_divider_reset
);

   // ==========================================================
   // declarations
   // ==========================================================
   logic                         aw_held;
   logic                         w_held;
   logic [tps_pkg::ADDR_W-1:0]   aw_addr_q;
   logic [tps_pkg::DATA_W-1:0]   w_data_q;
   logic                         w_lane0_q;
   logic                         wr_fire;
   logic                         gtc_wr;
   logic                         sel_wr;
   logic                         pwr_wr;
   logic                         sync_hold_bit;
   logic                         shared_divider_reset;
   logic                         timer1_power_off;
   tps_pkg::tps_sel_t            tick_source_select [tps_pkg::NUM_TIMERS];
   logic [tps_pkg::PRE_W-1:0]    div_cnt;
   logic                         tap8;
   logic                         tap64;
   logic                         tap256;
   logic                         tap1024;
   logic                         halt;
   logic [tps_pkg::NUM_TIMERS-1:0] next_timer_tick;
   logic [tps_pkg::DATA_W-1:0]   next_rdata;
   logic [1:0]                   next_rresp;

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b0;
         aw_held   <= 1'b0;
         aw_addr_q <= '0;
      end else if (awvalid && awready) begin
         awready   <= 1'b0;
         aw_held   <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (wr_fire) begin
         aw_held   <= 1'b0;
      end else if (!aw_held && !bvalid) begin
         awready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready    <= 1'b0;
         w_held    <= 1'b0;
         w_data_q  <= '0;
         w_lane0_q <= 1'b0;
      end else if (wvalid && wready) begin
         wready    <= 1'b0;
         w_held    <= 1'b1;
         w_data_q  <= wdata;
         w_lane0_q <= wstrb[0];
      end else if (wr_fire) begin
         w_held    <= 1'b0;
      end else if (!w_held && !bvalid) begin
         wready    <= 1'b1;
      end
   end

   // write takes effect once both halves are in; only byte lane 0 is live
   assign wr_fire = aw_held && w_held && !bvalid;
   assign gtc_wr  = wr_fire && w_lane0_q && (aw_addr_q == tps_pkg::GTC_OFS);
   assign sel_wr  = wr_fire && w_lane0_q && (aw_addr_q == tps_pkg::SEL_OFS);
   assign pwr_wr  = wr_fire && w_lane0_q && (aw_addr_q == tps_pkg::PWR_OFS);

   // write response, error for an address outside the map
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= tps_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         if ((aw_addr_q == tps_pkg::GTC_OFS) || (aw_addr_q == tps_pkg::SEL_OFS) ||
             (aw_addr_q == tps_pkg::PWR_OFS) || (aw_addr_q == tps_pkg::STAT_OFS)) begin
            bresp <= tps_pkg::RESP_OKAY;
         end else begin
            bresp <= tps_pkg::RESP_SLVERR;
         end
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // general_timer_control
   // ==========================================================
   // reset bits last one cycle unless the hold bit keeps them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_hold_bit        <= tps_pkg::GTC_RESET;
         second_divider_reset <= tps_pkg::GTC_RESET;
         shared_divider_reset <= tps_pkg::GTC_RESET;
      end else if (gtc_wr) begin
         sync_hold_bit        <= w_data_q[tps_pkg::HOLD_BIT];
         second_divider_reset <= w_data_q[tps_pkg::SECOND_RST_BIT];
         shared_divider_reset <= w_data_q[tps_pkg::SHARED_RST_BIT];
      end else if (!sync_hold_bit) begin
         second_divider_reset <= 1'b0;
         shared_divider_reset <= 1'b0;
      end
   end

   // ==========================================================
   // tick source selects and power control
   // ==========================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < tps_pkg::NUM_TIMERS; i++) begin
            tick_source_select[i] <= tps_pkg::tps_sel_t'(tps_pkg::SEL_RESET);
         end
      end else if (sel_wr) begin
         for (int i = 0; i < tps_pkg::NUM_TIMERS; i++) begin
            tick_source_select[i] <= tps_pkg::tps_sel_t'(
               w_data_q[i*tps_pkg::SEL_STRIDE +: tps_pkg::SEL_W]);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer1_power_off <= tps_pkg::PWR_RESET;
      end else if (pwr_wr) begin
         timer1_power_off <= w_data_q[tps_pkg::PWR1_BIT];
      end
   end

   // ==========================================================
   // shared divider
   // ==========================================================
   // free running; only aresetn and the shared reset bit stop and clear it
   always_ff @(posedge aclk) begin
      if (!aresetn || shared_divider_reset) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // taps fire once per period; phase is whatever the divider holds
   assign tap8    = &div_cnt[tps_pkg::TAP8_W-1:0];
   assign tap64   = &div_cnt[tps_pkg::TAP64_W-1:0];
   assign tap256  = &div_cnt[tps_pkg::TAP256_W-1:0];
   assign tap1024 = &div_cnt[tps_pkg::TAP1024_W-1:0];
   assign halt    = shared_divider_reset;

   // ==========================================================
   // per-timer source selection
   // ==========================================================
   generate
      for (genvar t = 0; t < tps_pkg::NUM_TIMERS; t++) begin : g_timer
         tps_pin_if pin_if ();
         logic      gate;

         assign pin_if.pin = ext_count_pin[t];

         tps_pin_sync u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pio     (pin_if.sync)
         );

         // timer 1 is held off while powered down
         assign gate = !halt && !((t == 1) && timer1_power_off);

         // each timer picks its own tick from the common taps or its pin
         always_comb begin
            case (tick_source_select[t])
               tps_pkg::SEL_OFF:      next_timer_tick[t] = 1'b0;
               tps_pkg::SEL_DIV1:     next_timer_tick[t] = gate;
               tps_pkg::SEL_DIV8:     next_timer_tick[t] = gate && tap8;
               tps_pkg::SEL_DIV64:    next_timer_tick[t] = gate && tap64;
               tps_pkg::SEL_DIV256:   next_timer_tick[t] = gate && tap256;
               tps_pkg::SEL_DIV1024:  next_timer_tick[t] = gate && tap1024;
               tps_pkg::SEL_EXT_FALL: next_timer_tick[t] = gate && pin_if.fall;
               tps_pkg::SEL_EXT_RISE: next_timer_tick[t] = gate && pin_if.rise;
               default:               next_timer_tick[t] = 1'b0;
            endcase
         end

         // a tick every cycle when undivided
         AST_DIV1_EVERY_CYCLE: assert property (
            @(posedge aclk) disable iff (!aresetn)
            (tick_source_select[t] == tps_pkg::SEL_DIV1) && gate |=> timer_tick[t])
            else $error("undivided source missed a tick");

         // no source means no tick
         AST_OFF_SILENT: assert property (
            @(posedge aclk) disable iff (!aresetn)
            (tick_source_select[t] == tps_pkg::SEL_OFF) |=> !timer_tick[t])
            else $error("tick with no source selected");

         // divide by 8 tap lands only at the period end
         AST_DIV8_PHASE: assert property (
            @(posedge aclk) disable iff (!aresetn)
            (tick_source_select[t] == tps_pkg::SEL_DIV8) && gate
            |=> (timer_tick[t] == ($past(div_cnt[2:0]) == 3'h7)))
            else $error("divide by 8 tick out of phase");

         // rising pin edge becomes a tick two or three samples later
         AST_EXT_RISE_DELAY: assert property (
            @(posedge aclk) disable iff (!aresetn)
            (tick_source_select[t] == tps_pkg::SEL_EXT_RISE) && gate && !gtc_wr &&
            !sel_wr && !pwr_wr && $rose(ext_count_pin[t]) |-> ##[2:3] timer_tick[t])
            else $error("rising pin edge not counted in time");

         // falling pin edge counted in falling mode
         AST_EXT_FALL_DELAY: assert property (
            @(posedge aclk) disable iff (!aresetn)
            (tick_source_select[t] == tps_pkg::SEL_EXT_FALL) && gate && !gtc_wr &&
            !sel_wr && !pwr_wr && $fell(ext_count_pin[t]) |-> ##[2:3] timer_tick[t])
            else $error("falling pin edge not counted in time");
      end
   endgenerate

   // tick outputs from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_tick <= '0;
      end else begin
         timer_tick <= next_timer_tick;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   // read word for the requested address
   always_comb begin
      next_rdata = '0;
      next_rresp = tps_pkg::RESP_OKAY;
      case (araddr)
         tps_pkg::GTC_OFS: begin
            next_rdata[tps_pkg::HOLD_BIT]       = sync_hold_bit;
            next_rdata[tps_pkg::SECOND_RST_BIT] = second_divider_reset;
            next_rdata[tps_pkg::SHARED_RST_BIT] = shared_divider_reset;
         end
         tps_pkg::SEL_OFS: begin
            for (int i = 0; i < tps_pkg::NUM_TIMERS; i++) begin
               next_rdata[i*tps_pkg::SEL_STRIDE +: tps_pkg::SEL_W] = tick_source_select[i];
            end
         end
         tps_pkg::PWR_OFS:  next_rdata[tps_pkg::PWR1_BIT] = timer1_power_off;
         tps_pkg::STAT_OFS: next_rdata[tps_pkg::PRE_W-1:0] = div_cnt;
         default:           next_rresp = tps_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= tps_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ==========================================================
   // checks on the divider and control bits
   // ==========================================================
   // divider keeps counting unless reset
   AST_FREE_RUN: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !shared_divider_reset |=> (div_cnt == $past(div_cnt) + 10'h001))
      else $error("divider did not advance");

   // shared reset silences both timers
   AST_RESET_BOTH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      shared_divider_reset |=> (timer_tick == '0))
      else $error("tick during divider reset");

   // unheld reset bit lasts a single cycle
   AST_SELF_CLEAR: assert property (
      @(posedge aclk) disable iff (!aresetn)
      shared_divider_reset && !sync_hold_bit && !gtc_wr |=> !shared_divider_reset)
      else $error("shared reset bit did not self-clear");

   // held reset stays and keeps the divider at zero
   AST_HOLD_KEEPS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sync_hold_bit && shared_divider_reset && !gtc_wr
      |=> shared_divider_reset && (div_cnt == '0))
      else $error("held reset was released");

   // dropping the hold bit frees both resets a cycle later
   AST_HOLD_RELEASE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $fell(sync_hold_bit) && !gtc_wr |=> !shared_divider_reset && !second_divider_reset)
      else $error("resets kept after hold cleared");

endmodule : tps_prescaler

//--- tps_pkg.sv
/*
 * constants for the timer prescaler and external count block: register
 * offsets, field positions, reset values, tick source codes, divider taps.
 * assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package tps_pkg;

   // ==========================================================
   // sizes
   // ==========================================================
   localparam int NUM_TIMERS = 2;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int PRE_W      = 10;   // divider width, longest tap is /1024

   // ==========================================================
   // register offsets (byte addresses)
   // ==========================================================
   localparam logic [ADDR_W-1:0] GTC_OFS  = 8'h00;  // general_timer_control
   localparam logic [ADDR_W-1:0] SEL_OFS  = 8'h04;  // tick source selects
   localparam logic [ADDR_W-1:0] PWR_OFS  = 8'h08;  // timer power control
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;  // divider count, read only

   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int HOLD_BIT       = 7;  // sync_hold_bit
   localparam int SECOND_RST_BIT = 1;  // second_divider_reset
   localparam int SHARED_RST_BIT = 0;  // shared_divider_reset
   localparam int SEL_W          = 3;
   localparam int SEL_STRIDE     = 4;  // timer n select at bits 4n+2:4n
   localparam int PWR1_BIT       = 0;  // timer1_power_off
   localparam logic       GTC_RESET = 1'b0;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic       PWR_RESET = 1'b0;

   // ==========================================================
   // divider taps: a tap fires when its low bits are all ones
   // ==========================================================
   localparam int TAP8_W    = 3;
   localparam int TAP64_W   = 6;
   localparam int TAP256_W  = 8;
   localparam int TAP1024_W = 10;

   // ==========================================================
   // bus answers
   // ==========================================================
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // tick source select codes
   typedef enum logic [2:0] {
      SEL_OFF      = 3'b000,
      SEL_DIV1     = 3'b001,
      SEL_DIV8     = 3'b010,
      SEL_DIV64    = 3'b011,
      SEL_DIV256   = 3'b100,
      SEL_DIV1024  = 3'b101,
      SEL_EXT_FALL = 3'b110,
      SEL_EXT_RISE = 3'b111
   } tps_sel_t;

endpackage : tps_pkg

//--- tps_pin_if.sv
/*
 * carrier between the top and one pin synchroniser: the raw count pin
 * and the one-cycle edge strobes. assumes the aclk domain on both sides.
 */
`timescale 1ns/1ps

interface tps_pin_if;
   logic pin;   // raw ext_count_pin level
   logic rise;  // rising edge seen on the synchronised pin
   logic fall;  // falling edge seen on the synchronised pin

   modport sync (input pin, output rise, output fall);
   modport user (output pin, input rise, input fall);
endinterface : tps_pin_if

//--- tps_pin_sync.sv
/*
 * ext_count_pin synchroniser and edge detector for one timer.
 * assumes aclk free running and aresetn synchronous, active low.
 */
`timescale 1ns/1ps

module tps_pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   tps_pin_if.sync  pio
);

   logic front;  // half-cycle stage, stands in for the high-phase latch
   logic sync;   // synchronised pin
   logic last;   // previous synchronised pin

   // ==========================================================
   // sampling chain
   // ==========================================================
   // front stage closes on the falling edge, as a latch open while aclk high
   always_ff @(negedge aclk) begin
      if (!aresetn) begin
         front <= 1'b0;
      end else begin
         front <= pio.pin;
      end
   end

   // synchroniser and edge history on the rising edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         sync <= front;
         last <= sync;
      end
   end

   // ==========================================================
   // edge detector
   // ==========================================================
   assign pio.rise = sync & ~last;
   assign pio.fall = ~sync & last;

endmodule : tps_pin_sync

//--- tps_ext_src.sv
/* far-side count source for the pins: toggles while run is high.
   assumes a 20 ns clock whose edges fall on 10 ns multiples. */
`timescale 1ns/1ps
module tps_ext_src (
   input  wire logic       run,
   input  wire logic [1:0] pace,
   output      logic       pin
);
   // ==========================================================
   // source
   // ==========================================================
   // edges stay 7 ns into a 20 ns step, clear of clock edges
   initial begin
      pin = 1'b0;
      #7;
      forever begin
         #(run ? 80 + 20 * pace : 20); // half period well over a cycle
         if (run) pin = ~pin; // stable whenever stopped
      end
   end
endmodule : tps_ext_src

//--- tps_prescaler_tb.sv
/* bench for tps_prescaler: models tick spacing and pin edge ticks.
   assumes tps_pkg, tps_pin_if, tps_pin_sync, tps_ext_src compiled. */
`timescale 1ns/1ps
module tps_prescaler_tb;
   // ==========================================================
   // signals and instances
   // ==========================================================
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, run, pin, sdr, sp;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv, seed;
   logic [1:0]  bresp, rresp, rs, tick, pace;
   int          bad_count, checks, cyc, u, per[2], last[2], hits[2], nedge[2];
   int          divs[8] = '{0, 1, 8, 64, 256, 1024, -2, -2};
   time         t_edge[2];
   tps_prescaler dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ext_count_pin({pin, pin}), .timer_tick(tick), .second_divider_reset(sdr));
   tps_ext_src src_u (.run, .pace, .pin);
   // clock, pin edge log, watchdog
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge pin) begin
      t_edge[0] = $time;
      nedge[0]++;
   end
   always @(negedge pin) begin
      t_edge[1] = $time;
      nedge[1]++;
   end
   initial begin
      #(40000 * 20);
      bad_count++;
      stop_test();
   end
   // ==========================================================
   // tasks
   // ==========================================================
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      rs = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd
   // set the expected tick periods, then run n cycles
   task automatic go(input int p0, input int p1, input int n);
      @(negedge aclk);
      per   = '{p0, p1};
      last  = '{-1, -1};
      hits  = '{0, 0};
      nedge = '{0, 0};
      repeat (n) @(negedge aclk);
      for (int t = 0; t < 2; t++) begin
         if (per[t] > 0) chk(32'(hits[t] >= n / per[t] - 2), 32'h1);
      end
   endtask : go
   task automatic cfg(input logic [7:0] a, input logic [31:0] d, input int p0, p1, n);
      go(-1, -1, 0);
      wr(a, d);
      chk(32'(rs), 32'(tps_pkg::RESP_OKAY));
      go(p0, p1, n);
   endtask : cfg
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // ==========================================================
   // model: each tick checked against period, phase and pin edge unless its period is -1
   // ==========================================================
   always @(posedge aclk) begin
      cyc++;
      for (int t = 0; t < 2; t++) begin
         if (tick[t] === 1'b1) begin
            hits[t]++;
            u = 1 - t;
            sp = per[t] > 0 && (last[t] < 0 || cyc - last[t] == per[t]);
            if (per[t] == -2) chk(32'(($time - t_edge[t]) inside {[40:100]}), 32'h1);
            else if (per[t] >= 0) chk(32'(sp), 32'h1);
            if (per[t] >= per[u] && per[u] > 0) chk(32'(tick[u]), 32'h1);
            last[t] = cyc;
         end
      end
   end
   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, run, aresetn} = '0;
      {awaddr, araddr, wdata, pace, bad_count, checks, cyc} = '0;
      seed = 32'h23c09ce5;
      per  = '{-1, -1};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(tps_pkg::GTC_OFS);
      chk(rv, 32'h0);
      rd(tps_pkg::SEL_OFS);
      chk(rv, 32'h0);
      rd(tps_pkg::PWR_OFS);
      chk(rv, 32'h0);
      rd(8'h10);
      chk({rv[29:0], rs}, {30'h0, tps_pkg::RESP_SLVERR});
      wr(8'h10, 32'h1);
      chk(32'(rs), 32'(tps_pkg::RESP_SLVERR));
      for (int c = 1; c <= 5; c++) begin
         cfg(tps_pkg::SEL_OFS, 32'((c % 5 + 1) * 16 + c), divs[c], divs[c % 5 + 1],
             3200);
      end
      cfg(tps_pkg::SEL_OFS, 32'h22, 8, 8, 200);
      cfg(tps_pkg::GTC_OFS, 32'h83, 0, 0, 100);
      rd(tps_pkg::GTC_OFS);
      chk(rv, 32'h83);
      chk(32'(sdr), 32'h1);
      rd(tps_pkg::STAT_OFS);
      chk(rv, 32'h0);
      cfg(tps_pkg::GTC_OFS, 32'h03, 8, 8, 200);
      rd(tps_pkg::GTC_OFS);
      chk({rv[30:0], sdr}, 32'h0);
      cfg(tps_pkg::GTC_OFS, 32'h01, 8, 8, 200);
      rd(tps_pkg::GTC_OFS);
      chk(rv, 32'h0);
      cfg(tps_pkg::SEL_OFS, 32'h11, 1, 1, 50);
      cfg(tps_pkg::PWR_OFS, 32'h1, 1, 0, 50);
      cfg(tps_pkg::PWR_OFS, 32'h0, 1, 1, 50);
      cfg(tps_pkg::SEL_OFS, 32'h0, 0, 0, 100);
      repeat (4) begin
         seed = lfsr(seed);
         cfg(tps_pkg::SEL_OFS, seed & 32'h77, -1, -1, 20);
         rd(tps_pkg::SEL_OFS);
         chk(rv, seed & 32'h77);
      end
      cfg(tps_pkg::SEL_OFS, 32'h67, -2, -2, 5);
      run = 1'b1;
      repeat (40) begin
         seed = lfsr(seed);
         pace = seed[1:0];
         repeat (12) @(negedge aclk);
      end
      run = 1'b0;
      repeat (10) @(negedge aclk);
      chk(32'(hits[0]), 32'(nedge[0]));
      chk(32'(hits[1]), 32'(nedge[1]));
      stop_test();
   end
endmodule : tps_prescaler_tb
